// File: design/rdv_pkg.sv
// shared constants, types and helpers for the date value registers
package rdv_pkg;

    localparam int unsigned NUM_SETS  = 4;
    localparam int unsigned NUM_WORDS = 2 * NUM_SETS;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_CURRENT = 8'h00;
    localparam logic [7:0] OFS_ALARM   = 8'h08;
    localparam logic [7:0] OFS_STAMP1  = 8'h10;
    localparam logic [7:0] OFS_STAMP2  = 8'h18;
    localparam logic [7:0] OFS_HIGH    = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h20;

    localparam int unsigned STATUS_ERR_BIT = 0;

    // implemented bits and power-on values of each word
    localparam logic [15:0] LOW_MASK   = 16'h3f07;
    localparam logic [15:0] HIGH_MASK  = 16'hff1f;
    localparam logic [15:0] LOW_RESET  = 16'h0106;
    localparam logic [15:0] HIGH_RESET = 16'h0001;

    localparam logic [3:0] DIGIT_MAX   = 4'h9;
    localparam logic [2:0] WEEKDAY_MAX = 3'h6;

    typedef logic [2:0] rdv_idx_t;

    typedef struct packed {
        logic [1:0] unused_hi;
        logic [1:0] day_tens_digit;
        logic [3:0] day_units_digit;
        logic [4:0] unused_lo;
        logic [2:0] weekday_number;
    } rdv_low_t;

    typedef struct packed {
        logic [3:0] year_tens_digit;
        logic [3:0] year_units_digit;
        logic [2:0] unused;
        logic       month_tens_bit;
        logic [3:0] month_units_digit;
    } rdv_high_t;

    typedef struct packed {
        logic     en;
        rdv_idx_t idx;
        logic [15:0] data;
    } rdv_wr_t;

    typedef struct packed {
        logic     hit;
        logic     status;
        rdv_idx_t idx;
    } rdv_dec_t;

    typedef struct packed {
        logic [NUM_WORDS-1:0][15:0] word;
        logic [15:0]                rd;
    } rdv_mem_st_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        err;
    } rdv_top_st_t;

    localparam rdv_mem_st_t MEM_RESET = '{word: {NUM_SETS{HIGH_RESET, LOW_RESET}}, rd: 16'h0000};
    localparam rdv_top_st_t TOP_RESET = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, err: 1'b0};

    function automatic logic [15:0] word_mask(input rdv_idx_t idx);
        return idx[0] ? HIGH_MASK : LOW_MASK;
    endfunction : word_mask

    function automatic logic word_valid(input rdv_idx_t idx, input logic [15:0] d);
        rdv_low_t  l;
        rdv_high_t h;
        l = d;
        h = d;
        if (idx[0]) begin
            return (h.year_tens_digit <= DIGIT_MAX) && (h.year_units_digit <= DIGIT_MAX)
                && (h.month_units_digit <= DIGIT_MAX);
        end
        return (l.day_units_digit <= DIGIT_MAX) && (l.weekday_number <= WEEKDAY_MAX);
    endfunction : word_valid

endpackage : rdv_pkg

// File: design/rdv_date_mem.sv
// storage for the four date register sets
`timescale 1ns/100ps
module rdv_date_mem
    import rdv_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // write port
    input  wire rdv_wr_t     wr,
    // read port
    input  wire rdv_idx_t    rd_idx,
    output wire logic [15:0] rd_data,
    // current date words
    output wire logic [15:0] cur_low,
    output wire logic [15:0] cur_high
);

    rdv_mem_st_t s_q;
    rdv_mem_st_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.rd = s_q.word[rd_idx];
        if (wr.en) begin
            // unimplemented bits never store, so they read as zero
            s_d.word[wr.idx] = wr.data & word_mask(wr.idx);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= MEM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data  = s_q.rd;
    assign cur_low  = s_q.word[0];
    assign cur_high = s_q.word[1];

    // every set shares one layout
    for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
        rdv_low_t  lw;
        rdv_high_t hw;
        assign lw = s_q.word[2*g];
        assign hw = s_q.word[2*g+1];

        day_range_a: assert property (@(posedge pclk) disable iff (!presetn)
            lw.day_units_digit <= DIGIT_MAX) else $error("day units digit out of range");
        weekday_number_range_a: assert property (@(posedge pclk) disable iff (!presetn)
            lw.weekday_number <= WEEKDAY_MAX) else $error("weekday out of range");
        low_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
            lw.unused_hi == 2'h0 && lw.unused_lo == 5'h00) else $error("low word unused bits set");
        year_range_a: assert property (@(posedge pclk) disable iff (!presetn)
            hw.year_tens_digit <= DIGIT_MAX && hw.year_units_digit <= DIGIT_MAX)
            else $error("year digit out of range");
        month_range_a: assert property (@(posedge pclk) disable iff (!presetn)
            hw.month_units_digit <= DIGIT_MAX && hw.unused == 3'h0) else $error("month field bad");
    end

endmodule : rdv_date_mem

// File: design/rdv_date_regs.sv
// apb slave for the date, alarm and timestamp date registers
`timescale 1ns/100ps

module rdv_date_regs
    import rdv_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    // current date and refused-write flag to the calendar
    output wire logic [15:0] date_low,
    output wire logic [15:0] date_high,
    output wire logic        write_rejected
);

    function automatic rdv_dec_t addr_decode(input logic [7:0] a);
        rdv_dec_t d;
        d = '0;
        d.status = (a == OFS_STATUS);
        d.hit    = (a[1:0] == 2'b00) && (a < OFS_STATUS);
        d.idx    = a[4:2];
        return d;
    endfunction : addr_decode

    rdv_top_st_t s_q;
    rdv_top_st_t s_d;
    rdv_dec_t    dec;
    rdv_wr_t     wr;
    logic [15:0] mem_rd;
    logic        wvalid;
    logic        done;
    logic        bad_wr;

    assign dec    = addr_decode(paddr);
    assign wvalid = word_valid(dec.idx, pwdata[15:0]);
    // completion edge: access phase with ready already high
    assign done   = psel && penable && s_q.pready;
    // out-of-range bcd digits are refused whole rather than stored
    assign bad_wr = done && pwrite && dec.hit && !wvalid;

    always_comb begin
        wr      = '0;
        wr.en   = done && pwrite && dec.hit && wvalid;
        wr.idx  = dec.idx;
        wr.data = pwdata[15:0];
    end

    rdv_date_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr),
        .rd_idx  (dec.idx),
        .rd_data (mem_rd),
        .cur_low (date_low),
        .cur_high(date_high)
    );

    always_comb begin
        s_d = s_q;
        // one wait state: the memory read lands in the first access cycle
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = !(dec.hit || dec.status) || (pwrite && dec.hit && !wvalid);
            if (!pwrite && dec.hit) begin
                s_d.prdata = {16'h0000, mem_rd};
            end else if (!pwrite && dec.status) begin
                s_d.prdata[STATUS_ERR_BIT] = s_q.err;
            end
        end
        // write one clears, but a refusal in the same cycle wins
        if (done && pwrite && dec.status && pwdata[STATUS_ERR_BIT]) begin
            s_d.err = 1'b0;
        end
        if (bad_wr) begin
            s_d.err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata         = s_q.prdata;
    assign pready         = s_q.pready;
    assign pslverr        = s_q.pslverr;
    assign write_rejected = s_q.err;

    ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("pready late");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held over two cycles");

    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !dec.hit && !dec.status |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && dec.hit && !dec.idx[0] |-> prdata[31:14] == 18'h00000 && prdata[7:3] == 5'h00)
        else $error("low word unused bits read nonzero");

    high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && dec.hit && dec.idx[0] |-> prdata[31:16] == 16'h0000 && prdata[7:5] == 3'h0)
        else $error("high word unused bits read nonzero");

    day_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr.en && wr.idx == 3'h0 |=> date_low == ($past(pwdata[15:0]) & LOW_MASK))
        else $error("low date word not stored");

    date_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr.en && wr.idx == 3'h1 |=> date_high == ($past(pwdata[15:0]) & HIGH_MASK))
        else $error("high date word not stored");

    reject_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        bad_wr && dec.idx == 3'h0 |=> pslverr == 1'b0 && write_rejected && $stable(date_low))
        else $error("refused write altered state");

    reject_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && dec.hit |-> pslverr == !wvalid)
        else $error("pslverr does not match digit check");

    sticky_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        write_rejected && !(done && pwrite && dec.status && pwdata[STATUS_ERR_BIT]) |=> write_rejected)
        else $error("error flag dropped");

    reset_value_a: assert property (@(posedge pclk)
        $rose(presetn) |-> date_low == LOW_RESET && date_high == HIGH_RESET)
        else $error("date reset values wrong");

    reset_bus_a: assert property (@(posedge pclk)
        $rose(presetn) |-> !pready && !pslverr && prdata == 32'h0000_0000 && !write_rejected)
        else $error("bus reset values wrong");

    // bus timing: one wait state, every answer a single-cycle pulse
    idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("bus outputs not idle");

    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");

    ready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready)
        else $error("pready without select");

    setup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> !pready)
        else $error("pready in setup cycle");

    ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel) && $past(penable))
        else $error("pready outside access phase");

    write_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data driven on write");

    // read path: the registered word must match the live date outputs
    low_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && dec.hit && dec.idx == 3'h0 |-> prdata == {16'h0000, date_low})
        else $error("low date word read wrong");

    high_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && dec.hit && dec.idx == 3'h1 |-> prdata == {16'h0000, date_high})
        else $error("high date word read wrong");

    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && dec.status |-> prdata[31:1] == 31'h0 && prdata[STATUS_ERR_BIT] == write_rejected)
        else $error("status read wrong");

    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && (dec.hit || dec.status) |-> !pslverr)
        else $error("mapped read refused");

    status_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && dec.status |-> !pslverr)
        else $error("status write refused");

    // error flag: set by a refused write, cleared by writing one or by reset
    err_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        bad_wr |=> write_rejected)
        else $error("error flag not set");

    err_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && dec.status && pwdata[STATUS_ERR_BIT] |=> !write_rejected)
        else $error("error flag not cleared");

    err_source_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(write_rejected) |-> $past(bad_wr))
        else $error("error flag set without refusal");

    low_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr.en && wr.idx == 3'h0) |=> $stable(date_low))
        else $error("low date word changed unwritten");

    high_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr.en && wr.idx == 3'h1) |=> $stable(date_high))
        else $error("high date word changed unwritten");

    unmapped_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && !dec.hit |=> $stable(date_low) && $stable(date_high))
        else $error("unmapped write altered date");

endmodule : rdv_date_regs

// File: testbench/testbench.sv
// self-checking bench for the date value registers
`timescale 1ns/100ps
module testbench;
    import rdv_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic        pready, pslverr, write_rejected, er;
    logic [15:0] date_low, date_high;
    logic [15:0] shadow [8];
    int          fails, comparisons, cycles, i;

    rdv_date_regs u_rdv_date_regs (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .date_low       (date_low),
        .date_high      (date_high),
        .write_rejected (write_rejected)
    );

    always #4 pclk = ~pclk;

    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one transfer; an idle edge follows so psel is never assigned twice at one edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no local limit: only the cycle ceiling ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // reset held two edges, then every word must be back at its power-on value
    task automatic reset_and_check();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("rejected after reset", write_rejected, 1'b0);
        for (i = 0; i < 8; i++) begin
            shadow[i] = i[0] ? 16'h0001 : 16'h0106;
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset word", rd, {16'h0000, shadow[i]});
        end
        check("date_low", date_low, 16'h0106);
        check("date_high", date_high, 16'h0001);
    endtask : reset_and_check

    // legal digits with junk in every unused bit
    function automatic logic [31:0] legal(input logic hi);
        if (hi) return {16'($urandom), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom), 4'($urandom % 10)};
        return {18'($urandom), 2'($urandom % 4), 4'($urandom % 10), 5'($urandom), 3'($urandom % 7)};
    endfunction : legal

    function automatic logic [15:0] stored(input logic hi, input logic [31:0] r);
        if (hi) return {r[15:8], 3'b000, r[4:0]};
        return {2'b00, r[13:8], 5'b00000, r[2:0]};
    endfunction : stored

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fails, comparisons, cycles} = '0;
        void'($urandom(97507));
        reset_and_check();
        $display("test reset done");
        for (int k = 0; k < 48; k++) begin
            i = $urandom_range(7);
            w = legal(i[0]);
            if (k == 0) w = 32'hffff_3906;
            if (k == 1) w = 32'hffff_99f9;
            apb(1'b1, 8'(i * 4), w);
            check("write err", er, 1'b0);
            shadow[i] = stored(i[0], w);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("readback", rd, {16'h0000, shadow[i]});
            check("read err", er, 1'b0);
            check("date_low", date_low, shadow[0]);
            check("date_high", date_high, shadow[1]);
        end
        $display("test random writes done");
        for (int k = 0; k < 16; k++) begin
            i = $urandom_range(7);
            w = legal(i[0]);
            if (i[0]) w[4 * ($urandom % 3 == 2 ? 0 : 2 + $urandom % 2) +: 4] = 4'($urandom_range(15, 10));
            else if (k[0]) w[11:8] = 4'($urandom_range(15, 10));
            else w[2:0] = 3'h7;
            apb(1'b1, 8'(i * 4), w);
            check("bad digit err", er, 1'b1);
            check("rejected flag", write_rejected, 1'b1);
            apb(1'b0, OFS_STATUS, 32'h0);
            check("status read", rd, 32'h0000_0001);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("unchanged", rd, {16'h0000, shadow[i]});
            apb(1'b1, OFS_STATUS, 32'h1);
            check("flag cleared", write_rejected, 1'b0);
        end
        $display("test refused writes done");
        apb(1'b1, OFS_CURRENT, 32'h0000_ffff);
        check("refused before reset", er, 1'b1);
        reset_and_check();
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status after reset", rd, 32'h0);
        $display("test reset again done");
        apb(1'b1, 8'h24, 32'h1);
        check("unmapped err", er, 1'b1);
        apb(1'b0, 8'h02, 32'h0);
        check("unaligned err", er, 1'b1);
        check("unaligned data", rd, 32'h0);
        $display("test unmapped done");
        test_done();
    end
endmodule : testbench
